// [core/fracn_pkg.sv]
package fracn_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register word index; byte address is four times the index
  localparam logic [2:0]  IDX_NUM    = 3'h1;
  localparam logic [2:0]  IDX_INT    = 3'h2;
  localparam logic [2:0]  IDX_DIV    = 3'h3;
  localparam logic [2:0]  IDX_FAST   = 3'h4;
  localparam logic [2:0]  IDX_STAT   = 3'h5;

  // writable bits of each 20-bit word, reserved bits read zero
  localparam logic [19:0] NUM_MASK   = 20'h3FFFF;
  localparam logic [19:0] INT_MASK   = 20'h7FFFF;
  localparam logic [19:0] DIV_MASK   = 20'h0FFFF;
  localparam logic [19:0] FAST_MASK  = 20'h1FFFF;

  // reset values; reference divider starts at its least legal ratio
  localparam logic [19:0] NUM_RST    = 20'h00000;
  localparam logic [19:0] INT_RST    = 20'h00000;
  localparam logic [19:0] DIV_RST    = 20'h00004;
  localparam logic [19:0] FAST_RST   = 20'h00000;

  // field positions
  localparam int          NUM_W      = 18;
  localparam int          INT_W      = 15;
  localparam int          CP1_LSB    = 15;
  localparam int          REFDIV_LSB = 0;
  localparam int          LDSRC_BIT  = 11;
  localparam int          WIN_LSB    = 12;
  localparam int          NOISE_SHAPING_RANDOMIZE_BIT   = 14;
  localparam int          HIZ_BIT    = 15;
  localparam int          FAST_LSB   = 0;
  localparam int          FAST_W     = 13;
  localparam int          CP2_LSB    = 13;
  localparam int          SPEN_BIT   = 16;

  localparam logic [7:0]  REFDIV_MIN = 8'h04;
  localparam logic [4:0]  CP1_OFS    = 5'h01;
  localparam logic [3:0]  CP2_OFS    = 4'h4;
  localparam int          LOCK_RUN   = 63;
  localparam int          LOSS_RUN   = 4;

  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic        ack;
    logic [31:0] rdata;
    logic [19:0] num_stage;
    logic [19:0] num_act;
    logic [19:0] int_w;
    logic [19:0] div_w;
    logic [19:0] fast_w;
    logic        commit;
    logic [2:0]  ref_sy;
    logic [2:0]  fb_sy;
    logic [2:0]  ps_sy;
    logic [7:0]  rcnt;
    logic        cmp;
    logic [17:0] acc;
    logic [15:0] divide;
    logic [12:0] fl_cnt;
    logic        fl_on;
    logic        win_open;
    logic [2:0]  err_cnt;
    logic        cmp_done;
    logic        in_win;
    logic        ld;
    logic [4:0]  nrm_steps;
    logic [3:0]  bst_steps;
  } top_st_t;

  typedef struct packed {
    logic [5:0]  good_cnt;
    logic [5:0]  bad_cnt;
    logic        locked;
  } ld_st_t;

endpackage : fracn_pkg

// [core/lock_filter.sv]
`timescale 1ns/1ps
module lock_filter #(
  parameter int LOCK_RUN = fracn_pkg::LOCK_RUN,
  parameter int LOSS_RUN = fracn_pkg::LOSS_RUN
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // comparison results
  input  wire logic done,
  input  wire logic in_win,
  input  wire logic clear,
  // result
  output logic      locked
);

  fracn_pkg::ld_st_t s_ff;
  fracn_pkg::ld_st_t nxt_s;

  if (LOCK_RUN < 1 || LOCK_RUN > 63 || LOSS_RUN < 1 || LOSS_RUN > 63) begin : g_chk
    $error("lock_filter: run lengths must be 1 to 63");
  end

  always_comb begin
    nxt_s = s_ff;
    if (clear) begin
      nxt_s = '0;
    end else if (done) begin
      if (in_win) begin
        nxt_s.bad_cnt = 6'h00;
        if (!s_ff.locked) begin
          if (s_ff.good_cnt == 6'(LOCK_RUN - 1)) begin
            nxt_s.locked   = 1'b1;
            nxt_s.good_cnt = 6'h00;
          end else begin
            nxt_s.good_cnt = s_ff.good_cnt + 6'h01;
          end
        end
      end else begin
        nxt_s.good_cnt = 6'h00;
        if (s_ff.locked) begin
          if (s_ff.bad_cnt == 6'(LOSS_RUN - 1)) begin
            nxt_s.locked  = 1'b0;
            nxt_s.bad_cnt = 6'h00;
          end else begin
            nxt_s.bad_cnt = s_ff.bad_cnt + 6'h01;
          end
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign locked = s_ff.locked;

endmodule : lock_filter

// [core/fracn_fastlock_lockdetect.sv]
// Register access over Wishbone and the address map were chosen for this implementation.
`timescale 1ns/1ps
// Overview of operation
// - output equals compare rate times (integer plus numerator over 2^18)
// - numerator is 18-bit two's complement; negative is modulus minus magnitude
// - compare rate is reference input divided by reference divider ratio
// - fast lock allowed only while speedup_enable (word 4 bit 16) is one
// - fast lock starts on frequency commit or power_save_n rising
// - during fast lock switch closed and boost pump used, then normal pump
// - fast lock lasts speedup count (word 4 bits 12:0) compare periods
// - normal pump code word 2 bits 18:15, current steps code plus one
// - boost pump code word 4 bits 15:13, current steps code plus four
// - lock source bit one: raw phase detector result on lock_indicator
// - lock source bit zero: lock_indicator from digital lock detect
// - lock window code 0,1,2 gives threshold of 1,2,3 reference periods
// - digital mode: lock_indicator low on every new frequency setting
// - digital mode: lock after 63 consecutive comparisons inside window
// - digital mode: unlock after a run of comparisons outside window
// - numerator write takes effect only with following integer write
// - power save keeps registers and puts pump output in high impedance
module fracn_fastlock_lockdetect #(
  parameter int AW       = 8,
  parameter int LOCK_RUN = fracn_pkg::LOCK_RUN,
  parameter int LOSS_RUN = fracn_pkg::LOSS_RUN
) (
  // clock and reset
  input  wire logic          REF_CLK,
  input  wire logic          RESET,
  // wishbone slave
  input  wire logic          WB_CYC_I,
  input  wire logic          WB_STB_I,
  input  wire logic          WB_WE_I,
  input  wire logic [AW-1:0] WB_ADR_I,
  input  wire logic [3:0]    WB_SEL_I,
  input  wire logic [31:0]   WB_DAT_I,
  output logic      [31:0]   WB_DAT_O,
  output logic               WB_ACK_O,
  // pins, asynchronous to REF_CLK
  input  wire logic          REFERENCE_INPUT,
  input  wire logic          FEEDBACK_INPUT,
  input  wire logic          POWER_SAVE_N,
  // loop control
  output logic      [15:0]   DIVIDE_VALUE,
  output logic               COMPARE_RATE,
  output logic               LOOP_SWITCH_CLOSED,
  output logic               BOOST_PUMP_ON,
  output logic               NORMAL_PUMP_ON,
  output logic               PUMP_HIZ,
  output logic      [3:0]    NORMAL_PUMP_CURRENT_CODE,
  output logic      [4:0]    NORMAL_PUMP_STEPS,
  output logic      [2:0]    BOOST_PUMP_CURRENT_CODE,
  output logic      [3:0]    BOOST_PUMP_STEPS,
  output logic               NOISE_SHAPING_RANDOMIZE,
  // lock indication
  output logic               LOCK_INDICATOR
);

  if (AW < 5) begin : g_chk
    $error("fracn_fastlock_lockdetect: AW must be at least 5");
  end

  // refused here too, so a bad override names the top and not only the filter
  if (LOCK_RUN < 1 || LOCK_RUN > 63 || LOSS_RUN < 1 || LOSS_RUN > 63) begin : g_run_chk
    $error("fracn_fastlock_lockdetect: run lengths must be 1 to 63");
  end

  fracn_pkg::top_st_t s_ff;
  fracn_pkg::top_st_t nxt_s;

  logic        dig_locked;
  logic        hit;
  logic [2:0]  idx;
  logic        ref_edge;
  logic        fb_edge;
  logic        ps_rise;
  logic        ps_on;
  logic [7:0]  ref_div;
  logic [1:0]  win_code;
  logic [2:0]  thr;
  logic        spd_en;
  logic [12:0] spd_cnt;

  logic [18:0] acc_sum;
  logic        neg;
  logic [15:0] div_next;

  logic        req_new;
  logic        wr_take;
  logic        ph_event;

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [19:0] merge(input logic [19:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0]  sel,
                                        input logic [19:0] mask);
    logic [31:0] r;
    r = {12'h000, old};
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    return r[19:0] & mask;
  endfunction : merge

  // code 3 has no defined window; treat it as the widest one
  function automatic logic [2:0] window_limit(input logic [1:0] code);
    logic [2:0] lim;
    case (code)
      2'h0: begin
        lim = 3'h1;
      end
      2'h1: begin
        lim = 3'h2;
      end
      2'h2: begin
        lim = 3'h3;
      end
      default: begin
        lim = 3'h3;
      end
    endcase
    return lim;
  endfunction : window_limit

  // integer part per compare: a negative numerator borrows one, a carry adds one
  function automatic logic [15:0] divide_of(input logic [14:0] whole,
                                            input logic        borrow,
                                            input logic        carry);
    logic [15:0] d;
    d = {1'b0, whole};
    d = d - {15'h0000, borrow};
    d = d + {15'h0000, carry};
    return d;
  endfunction : divide_of

  ////////////////////////////////////////////////////////////////////////////
  // decode and field views of the stored words
  assign idx      = WB_ADR_I[4:2];
  assign hit      = (WB_ADR_I[AW-1:5] == '0);
  assign ref_edge = s_ff.ref_sy[1] & ~s_ff.ref_sy[2];
  assign fb_edge  = s_ff.fb_sy[1] & ~s_ff.fb_sy[2];
  assign ps_rise  = s_ff.ps_sy[1] & ~s_ff.ps_sy[2];
  assign ps_on    = s_ff.ps_sy[1];
  assign ref_div  = s_ff.div_w[fracn_pkg::REFDIV_LSB +: 8];
  assign win_code = s_ff.div_w[fracn_pkg::WIN_LSB +: 2];
  assign spd_en   = s_ff.fast_w[fracn_pkg::SPEN_BIT];
  assign spd_cnt  = s_ff.fast_w[fracn_pkg::FAST_LSB +: fracn_pkg::FAST_W];
  assign neg      = s_ff.num_act[fracn_pkg::NUM_W-1];
  assign acc_sum  = {1'b0, s_ff.acc} + {1'b0, s_ff.num_act[fracn_pkg::NUM_W-1:0]};
  assign thr      = window_limit(win_code);
  assign div_next = divide_of(s_ff.int_w[fracn_pkg::INT_W-1:0], neg, acc_sum[18]);

  // a held strobe is answered every other cycle: only a request seen while ack is low is new
  assign req_new  = WB_CYC_I & WB_STB_I & ~s_ff.ack;
  assign wr_take  = WB_CYC_I & WB_STB_I & WB_WE_I & s_ff.ack & hit;
  // either the divided reference or the feedback edge opens or closes a window
  assign ph_event = s_ff.cmp | fb_edge;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    nxt_s        = s_ff;
    nxt_s.commit = 1'b0;
    nxt_s.cmp    = 1'b0;
    nxt_s.cmp_done = 1'b0;

    // pin synchronisers; only stage 1 and 2 are read by logic
    nxt_s.ref_sy = {s_ff.ref_sy[1:0], REFERENCE_INPUT};
    nxt_s.fb_sy  = {s_ff.fb_sy[1:0], FEEDBACK_INPUT};
    nxt_s.ps_sy  = {s_ff.ps_sy[1:0], POWER_SAVE_N};

    // bus: ack one cycle after request, write lands when ack is seen
    nxt_s.ack = req_new;
    if (req_new) begin
      nxt_s.rdata = 32'h0000_0000;
      if (hit) begin
        case (idx)
          fracn_pkg::IDX_NUM: begin
            nxt_s.rdata = {12'h000, s_ff.num_stage};
          end
          fracn_pkg::IDX_INT: begin
            nxt_s.rdata = {12'h000, s_ff.int_w};
          end
          fracn_pkg::IDX_DIV: begin
            nxt_s.rdata = {12'h000, s_ff.div_w};
          end
          fracn_pkg::IDX_FAST: begin
            nxt_s.rdata = {12'h000, s_ff.fast_w};
          end
          fracn_pkg::IDX_STAT: begin
            nxt_s.rdata = {3'h0, s_ff.fl_cnt, 13'h0000,
                           dig_locked, s_ff.fl_on, s_ff.ld};
          end
          default: begin
            nxt_s.rdata = 32'h0000_0000;
          end
        endcase
      end
    end

    // registers keep their contents in power save: nothing here looks at it
    if (wr_take) begin
      case (idx)
        fracn_pkg::IDX_NUM: begin
          // staged only; takes effect with the next integer write
          nxt_s.num_stage = merge(s_ff.num_stage, WB_DAT_I, WB_SEL_I,
                                  fracn_pkg::NUM_MASK);
        end
        fracn_pkg::IDX_INT: begin
          nxt_s.int_w   = merge(s_ff.int_w, WB_DAT_I, WB_SEL_I,
                                fracn_pkg::INT_MASK);
          nxt_s.num_act = s_ff.num_stage;
          nxt_s.commit  = 1'b1;
        end
        fracn_pkg::IDX_DIV: begin
          nxt_s.div_w = merge(s_ff.div_w, WB_DAT_I, WB_SEL_I,
                              fracn_pkg::DIV_MASK);
        end
        fracn_pkg::IDX_FAST: begin
          nxt_s.fast_w = merge(s_ff.fast_w, WB_DAT_I, WB_SEL_I,
                               fracn_pkg::FAST_MASK);
        end
        default: begin
        end
      endcase
    end

    // reference divider; ratios below the least legal one use it
    if (ref_edge) begin
      if (s_ff.rcnt >= ((ref_div < fracn_pkg::REFDIV_MIN) ?
                        fracn_pkg::REFDIV_MIN - 8'h01 : ref_div - 8'h01)) begin
        nxt_s.rcnt = 8'h00;
        nxt_s.cmp  = 1'b1;
      end else begin
        nxt_s.rcnt = s_ff.rcnt + 8'h01;
      end
    end

    // fraction accumulator: negative numerator borrows one from the integer
    if (s_ff.cmp) begin
      nxt_s.acc    = acc_sum[17:0];
      nxt_s.divide = div_next;
    end

    // fast lock timer, counted in compare periods; a count of zero never starts it
    if (spd_en & (s_ff.commit | ps_rise)) begin
      nxt_s.fl_cnt = spd_cnt;
      nxt_s.fl_on  = (spd_cnt != 13'h0000);
    end else if (s_ff.fl_on & s_ff.cmp) begin
      nxt_s.fl_cnt = s_ff.fl_cnt - 13'h0001;
      if (s_ff.fl_cnt == 13'h0001) begin
        nxt_s.fl_on = 1'b0;
      end
    end

    // phase comparison: window opens on the first of the two edges
    // both edges in one cycle: no reference edge between them, zero error
    if (!s_ff.win_open) begin
      if (s_ff.cmp & fb_edge) begin
        nxt_s.cmp_done = 1'b1;
        nxt_s.in_win   = 1'b1;
      end else if (ph_event) begin
        nxt_s.win_open = 1'b1;
        nxt_s.err_cnt  = 3'h0;
      end
    end else begin
      if (ref_edge & (s_ff.err_cnt != 3'h7)) begin
        nxt_s.err_cnt = s_ff.err_cnt + 3'h1;
      end
      if (ph_event) begin
        nxt_s.win_open = 1'b0;
        nxt_s.cmp_done = 1'b1;
        nxt_s.in_win   = (s_ff.err_cnt < thr);
      end
    end

    // lock indicator source
    // raw mode shows an open window as low, one cycle late
    if (s_ff.div_w[fracn_pkg::LDSRC_BIT]) begin
      nxt_s.ld = ~s_ff.win_open;
    end else begin
      nxt_s.ld = dig_locked & ~s_ff.commit;
    end


    // step counts sit in flops so the pump outputs never glitch
    nxt_s.nrm_steps = {1'b0, s_ff.int_w[fracn_pkg::CP1_LSB +: 4]}
                      + fracn_pkg::CP1_OFS;
    nxt_s.bst_steps = {1'b0, s_ff.fast_w[fracn_pkg::CP2_LSB +: 3]}
                      + fracn_pkg::CP2_OFS;
  end

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      s_ff           <= '0;
      s_ff.num_stage <= fracn_pkg::NUM_RST;
      s_ff.num_act   <= fracn_pkg::NUM_RST;
      s_ff.int_w     <= fracn_pkg::INT_RST;
      s_ff.div_w     <= fracn_pkg::DIV_RST;
      s_ff.fast_w    <= fracn_pkg::FAST_RST;
    end else begin
      s_ff <= nxt_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // consecutive-comparison filter, restarted by every frequency commit
  lock_filter #(
    .LOCK_RUN (LOCK_RUN),
    .LOSS_RUN (LOSS_RUN)
  ) u_filter (
    .clk    (REF_CLK),
    .rst    (RESET),
    .done   (s_ff.cmp_done),
    .in_win (s_ff.in_win),
    .clear  (s_ff.commit),
    .locked (dig_locked)
  );

  ////////////////////////////////////////////////////////////////////////////
  assign WB_DAT_O                 = s_ff.rdata;
  assign WB_ACK_O                 = s_ff.ack;
  assign DIVIDE_VALUE             = s_ff.divide;
  assign COMPARE_RATE             = s_ff.cmp;
  // boost pump and switch only while the timer runs
  assign LOOP_SWITCH_CLOSED       = s_ff.fl_on;
  assign BOOST_PUMP_ON            = s_ff.fl_on & ps_on;
  assign NORMAL_PUMP_ON           = ~s_ff.fl_on & ps_on;
  assign PUMP_HIZ                 = ~ps_on | s_ff.div_w[fracn_pkg::HIZ_BIT];

  // codes pass straight from the stored words
  assign NORMAL_PUMP_CURRENT_CODE = s_ff.int_w[fracn_pkg::CP1_LSB +: 4];
  assign NORMAL_PUMP_STEPS        = s_ff.nrm_steps;
  assign BOOST_PUMP_CURRENT_CODE  = s_ff.fast_w[fracn_pkg::CP2_LSB +: 3];
  assign BOOST_PUMP_STEPS         = s_ff.bst_steps;
  assign NOISE_SHAPING_RANDOMIZE  = s_ff.div_w[fracn_pkg::NOISE_SHAPING_RANDOMIZE_BIT];
  assign LOCK_INDICATOR           = s_ff.ld;

endmodule : fracn_fastlock_lockdetect

// [dv/loop_partner.sv]
`timescale 1ns/1ps
module loop_partner (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // compare in, divided vco edge out
  input  wire logic       cmp,
  input  wire logic [7:0] lag,
  output logic            fb
);
  logic [7:0] dly_ff;
  logic       run_ff;
  logic [2:0] hi_ff;

  // a long lag stands for a loop far from lock; the pin is always driven
  always_ff @(posedge clk) begin
    if (rst) begin
      dly_ff <= 8'h00;
      run_ff <= 1'b0;
      hi_ff  <= 3'h0;
    end else if (cmp) begin
      dly_ff <= lag;
      run_ff <= 1'b1;
    end else if (run_ff && dly_ff != 8'h00) begin
      dly_ff <= dly_ff - 8'h01;
    end else if (run_ff) begin
      run_ff <= 1'b0;
      hi_ff  <= 3'h7;
    end else if (hi_ff != 3'h0) begin
      hi_ff <= hi_ff - 3'h1;
    end
  end
  assign fb = hi_ff != 3'h0;
endmodule : loop_partner

// [dv/fracn_sva.sv]
`timescale 1ns/1ps
module fracn_sva #(
  parameter int AW       = 8,
  parameter int LOCK_RUN = fracn_pkg::LOCK_RUN,
  parameter int LOSS_RUN = fracn_pkg::LOSS_RUN
) (
  // clock and reset
  input wire logic          REF_CLK,
  input wire logic          RESET,
  // bus
  input wire logic          WB_CYC_I,
  input wire logic          WB_STB_I,
  input wire logic          WB_WE_I,
  input wire logic [AW-1:0] WB_ADR_I,
  input wire logic [31:0]   WB_DAT_I,
  input wire logic          WB_ACK_O,
  // loop control
  input wire logic          COMPARE_RATE,
  input wire logic          LOOP_SWITCH_CLOSED,
  input wire logic          BOOST_PUMP_ON,
  input wire logic          NORMAL_PUMP_ON,
  input wire logic [3:0]    NORMAL_PUMP_CURRENT_CODE,
  input wire logic [4:0]    NORMAL_PUMP_STEPS,
  input wire logic [2:0]    BOOST_PUMP_CURRENT_CODE,
  input wire logic [3:0]    BOOST_PUMP_STEPS,
  input wire logic          LOCK_INDICATOR
);
  logic       wr_ok;
  logic       raw_ff;
  logic [5:0] run_ff;
  assign wr_ok = WB_CYC_I && WB_STB_I && WB_WE_I && WB_ACK_O;

  // source bit and compares since last commit, rebuilt from the bus
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      raw_ff <= 1'b0;
      run_ff <= 6'h00;
    end else begin
      if (wr_ok && WB_ADR_I == AW'(8'h0C)) raw_ff <= WB_DAT_I[11];
      if (wr_ok && WB_ADR_I == AW'(8'h08)) run_ff <= 6'h00;
      else if (COMPARE_RATE && run_ff != 6'h3F) run_ff <= run_ff + 6'h01;
    end
  end

  ////////////////////////////////////////////////////////////
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RESET);

  a_ack_after_req: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
    else $error("ack missing");
  a_ack_one_pulse: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack longer than one cycle");
  a_normal_steps: assert property (!$past(RESET) && $stable(NORMAL_PUMP_CURRENT_CODE)
    |-> NORMAL_PUMP_STEPS == {1'b0, NORMAL_PUMP_CURRENT_CODE} + 5'h01)
    else $error("normal pump steps wrong");
  a_boost_steps: assert property (!$past(RESET) && $stable(BOOST_PUMP_CURRENT_CODE)
    |-> BOOST_PUMP_STEPS == {1'b0, BOOST_PUMP_CURRENT_CODE} + 4'h4)
    else $error("boost pump steps wrong");
  a_pump_swap: assert property (NORMAL_PUMP_ON |-> !BOOST_PUMP_ON && !LOOP_SWITCH_CLOSED)
    else $error("normal pump with switch closed");
  a_boost_in_fast: assert property (BOOST_PUMP_ON |-> LOOP_SWITCH_CLOSED)
    else $error("boost pump outside fast lock");
  a_compare_gap: assert property (COMPARE_RATE |=> !COMPARE_RATE [*7])
    else $error("compares too close");
  a_switch_opens: assert property ($fell(LOOP_SWITCH_CLOSED) |->
    COMPARE_RATE || $past(COMPARE_RATE) || $past(COMPARE_RATE, 2))
    else $error("switch opened off a compare");
  a_commit_unlocks: assert property (wr_ok && WB_ADR_I == AW'(8'h08) && !raw_ff |->
    ##[1:3] !LOCK_INDICATOR)
    else $error("lock held across commit");
  a_lock_after_run: assert property ($rose(LOCK_INDICATOR) && !raw_ff
    && !$past(raw_ff, 2) |-> run_ff >= 6'(LOCK_RUN - 1))
    else $error("lock raised too early");

  c_fast: cover property ($rose(LOOP_SWITCH_CLOSED));
  c_lock: cover property ($rose(LOCK_INDICATOR) && !raw_ff);
  c_loss: cover property ($fell(LOCK_INDICATOR) && !raw_ff);
endmodule : fracn_sva

bind fracn_fastlock_lockdetect fracn_sva #(.AW(AW), .LOCK_RUN(LOCK_RUN), .LOSS_RUN(LOSS_RUN))
  u_sva (.REF_CLK, .RESET, .WB_CYC_I, .WB_STB_I, .WB_WE_I, .WB_ADR_I, .WB_DAT_I, .WB_ACK_O,
  .COMPARE_RATE, .LOOP_SWITCH_CLOSED, .BOOST_PUMP_ON, .NORMAL_PUMP_ON, .NORMAL_PUMP_CURRENT_CODE,
  .NORMAL_PUMP_STEPS, .BOOST_PUMP_CURRENT_CODE, .BOOST_PUMP_STEPS, .LOCK_INDICATOR);

// [dv/test_fracn_fastlock_lockdetect.sv]
`timescale 1ns/1ps
module test_fracn_fastlock_lockdetect;
  typedef struct packed {logic [7:0] adr; logic [3:0] sel; logic [31:0] wd, exp;} row_t;
  logic        REF_CLK = 1'b0, RESET = 1'b1, WB_CYC_I = 1'b0, WB_STB_I = 1'b0, WB_WE_I = 1'b0;
  logic        POWER_SAVE_N = 1'b1, WB_ACK_O, FEEDBACK_INPUT, COMPARE_RATE, prev;
  logic        LOOP_SWITCH_CLOSED, BOOST_PUMP_ON, NORMAL_PUMP_ON, PUMP_HIZ, LOCK_INDICATOR;
  logic        NOISE_SHAPING_RANDOMIZE;
  logic [7:0]  WB_ADR_I = 8'h00, lag = 8'h02;
  logic [3:0]  WB_SEL_I = 4'hF, NORMAL_PUMP_CURRENT_CODE, BOOST_PUMP_STEPS;
  logic [31:0] WB_DAT_I = 32'h0, WB_DAT_O, rd, s;
  logic [15:0] DIVIDE_VALUE;
  logic [4:0]  NORMAL_PUMP_STEPS;
  logic [2:0]  BOOST_PUMP_CURRENT_CODE;
  logic [1:0]  rc = 2'h0;
  wire         REFERENCE_INPUT = rc[1];
  int          fails = 0, tests_run = 0, n;
  row_t        rows [0:8] = '{'{8'h04, 4'hF, 32'hFFFFFFFF, 32'h3FFFF},
    '{8'h08, 4'hF, 32'hFFFFFFFF, 32'h7FFFF}, '{8'h0C, 4'hF, 32'hFFFFFFFF, 32'h0FFFF},
    '{8'h10, 4'hF, 32'hFFFFFFFF, 32'h1FFFF}, '{8'h10, 4'h1, 32'h0, 32'h1FF00},
    '{8'h00, 4'hF, 32'hFFFFFFFF, 32'h0}, '{8'h1C, 4'hF, 32'hFFFFFFFF, 32'h0},
    '{8'h04, 4'hF, 32'h23333, 32'h23333}, '{8'h24, 4'hF, 32'hFFFFFFFF, 32'h0}};

  fracn_fastlock_lockdetect dut (.REF_CLK, .RESET, .WB_CYC_I, .WB_STB_I, .WB_WE_I, .WB_ADR_I,
    .WB_SEL_I, .WB_DAT_I, .WB_DAT_O, .WB_ACK_O, .REFERENCE_INPUT, .FEEDBACK_INPUT, .POWER_SAVE_N,
    .DIVIDE_VALUE, .COMPARE_RATE, .LOOP_SWITCH_CLOSED, .BOOST_PUMP_ON, .NORMAL_PUMP_ON, .PUMP_HIZ,
    .NORMAL_PUMP_CURRENT_CODE, .NORMAL_PUMP_STEPS, .BOOST_PUMP_CURRENT_CODE, .BOOST_PUMP_STEPS,
    .NOISE_SHAPING_RANDOMIZE, .LOCK_INDICATOR);
  loop_partner vco (.clk(REF_CLK), .rst(RESET), .cmp(COMPARE_RATE), .lag(lag), .fb(FEEDBACK_INPUT));

  initial forever #2 REF_CLK = ~REF_CLK;
  // reference pin at a quarter of the clock
  always @(posedge REF_CLK) rc <= rc + 2'h1;

  ////////////////////////////////////////////////////////////
  task automatic complete_run;
    if (fails == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : complete_run

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // ack looked at mid-cycle, i.e. as the next rising edge will sample it
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] wd,
                    input logic [3:0] sel = 4'hF);
    int k = 0;
    @(posedge REF_CLK);
    {WB_CYC_I, WB_STB_I, WB_WE_I, WB_ADR_I, WB_DAT_I, WB_SEL_I} <= {2'h3, we, adr, wd, sel};
    do begin
      @(negedge REF_CLK);
      k++;
    end while (WB_ACK_O !== 1'b1 && k < 50);
    if (k >= 50) begin
      fails++;
      complete_run();
    end
    rd = WB_DAT_O;
    @(posedge REF_CLK);
    {WB_CYC_I, WB_STB_I} <= 2'h0;
  endtask : wb

  task automatic wait_cmp(input int k);
    int g = 0;
    while (k > 0 && g < 9000) begin
      @(negedge REF_CLK);
      g++;
      if (COMPARE_RATE === 1'b1) k--;
    end
    if (k > 0) begin
      fails++;
      complete_run();
    end
  endtask : wait_cmp

  task automatic div_sum;
    s = 32'h0;
    repeat (8) begin
      wait_cmp(1);
      s = s + 32'(DIVIDE_VALUE);
    end
  endtask : div_sum

  task automatic set_lag(input logic [7:0] v);
    @(posedge REF_CLK) lag <= v;
  endtask : set_lag

  ////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge REF_CLK);
    RESET <= 1'b0;
    for (int i = 1; i < 5; i++) begin
      wb(1'b0, 8'(i * 4), 32'h0);
      check("reset word", (i == 3) ? 32'h4 : 32'h0, rd);
    end
    check("reset outputs", 32'h28, {NORMAL_PUMP_STEPS, BOOST_PUMP_STEPS, LOCK_INDICATOR});
    foreach (rows[i]) begin
      wb(1'b1, rows[i].adr, rows[i].wd, rows[i].sel);
      wb(1'b0, rows[i].adr, 32'h0);
      check("readback", rows[i].exp, rd);
    end
    wb(1'b0, 8'h04, 32'h0);
    check("word1 kept", 32'h23333, rd);
    // staged numerator of minus one half must not act before the integer write
    wb(1'b1, 8'h0C, 32'h00010);
    wb(1'b1, 8'h10, 32'h0);
    wb(1'b1, 8'h04, 32'h0);
    wb(1'b1, 8'h08, 32'h001D1);
    wb(1'b1, 8'h04, 32'h20000);
    wait_cmp(2);
    div_sum();
    check("divide sum staged", 32'hE88, s);
    wb(1'b1, 8'h08, 32'h001D1);
    wait_cmp(2);
    div_sum();
    check("divide sum", 32'hE84, s);
    for (int c = 0; c < 16; c++) begin
      wb(1'b1, 8'h08, {13'h0, c[3:0], 15'h1D1});
      repeat (2) @(negedge REF_CLK);
      check("normal code", 32'(c * 33 + 1), {NORMAL_PUMP_CURRENT_CODE, NORMAL_PUMP_STEPS});
    end
    for (int c = 0; c < 8; c++) begin
      wb(1'b1, 8'h10, {16'h0, c[2:0], 13'h0});
      repeat (2) @(negedge REF_CLK);
      check("boost code", 32'(c * 17 + 4), {BOOST_PUMP_CURRENT_CODE, BOOST_PUMP_STEPS});
    end
    wb(1'b1, 8'h10, 32'h00005);
    wb(1'b1, 8'h08, 32'h001D1);
    repeat (4) @(negedge REF_CLK);
    check("switch disabled", 32'h0, LOOP_SWITCH_CLOSED);
    wb(1'b1, 8'h10, 32'h10005);
    wb(1'b1, 8'h08, 32'h001D1);
    n = 0;
    s = 0;
    prev = 1'b0;
    while (n < 2000 && (n < 4 || LOOP_SWITCH_CLOSED === 1'b1)) begin
      @(negedge REF_CLK);
      n++;
      if (n == 3) check("fast on", 32'h6, {LOOP_SWITCH_CLOSED, BOOST_PUMP_ON, NORMAL_PUMP_ON});
      if (COMPARE_RATE === 1'b1 && (LOOP_SWITCH_CLOSED === 1'b1 || prev)) s++;
      prev = LOOP_SWITCH_CLOSED;
    end
    check("fast periods", 32'h5, s);
    check("fast off", 32'h1, {LOOP_SWITCH_CLOSED, BOOST_PUMP_ON, NORMAL_PUMP_ON});
    @(posedge REF_CLK) POWER_SAVE_N <= 1'b0;
    repeat (6) @(negedge REF_CLK);
    check("pump hiz", 32'h1, PUMP_HIZ);
    wb(1'b0, 8'h10, 32'h0);
    check("word kept", 32'h10005, rd);
    @(posedge REF_CLK) POWER_SAVE_N <= 1'b1;
    repeat (6) @(negedge REF_CLK);
    check("fast on wake", 32'h1, LOOP_SWITCH_CLOSED);
    // lag 2 gives one reference edge of phase error
    wb(1'b1, 8'h08, 32'h001D1);
    wait_cmp(80);
    check("narrow window", 32'h0, LOCK_INDICATOR);
    wb(1'b1, 8'h0C, 32'h03010);
    wb(1'b1, 8'h08, 32'h001D1);
    wait_cmp(62);
    check("lock early", 32'h0, LOCK_INDICATOR);
    wait_cmp(2);
    check("lock", 32'h1, LOCK_INDICATOR);
    wb(1'b1, 8'h08, 32'h001D1);
    repeat (3) @(negedge REF_CLK);
    check("commit unlock", 32'h0, LOCK_INDICATOR);
    wait_cmp(64);
    set_lag(8'h1E);
    wait_cmp(7);
    check("loss", 32'h0, LOCK_INDICATOR);
    set_lag(8'h02);
    wait_cmp(40);
    set_lag(8'h1E);
    wait_cmp(1);
    set_lag(8'h02);
    wait_cmp(61);
    check("run restarted", 32'h0, LOCK_INDICATOR);
    wait_cmp(3);
    check("relock", 32'h1, LOCK_INDICATOR);
    wb(1'b1, 8'h0C, 32'h00810);
    s = 0;
    repeat (64) begin
      @(negedge REF_CLK);
      if (LOCK_INDICATOR === 1'b0) s[0] = 1'b1;
      if (LOCK_INDICATOR === 1'b1) s[1] = 1'b1;
    end
    check("raw follows detector", 32'h3, s);
    complete_run();
  end
endmodule : test_fracn_fastlock_lockdetect
